// file: rtl/rdq_params.svh
// Constants of the soft-interrupt stream host: opcodes, packet words, register map.
// Assumes inclusion by bare name from the host design files.
`ifndef RDQ_PARAMS_SVH
`define RDQ_PARAMS_SVH

// Opcode nibble, low bits of the first packet word
`define RDQ_OP_SET      4'h1
`define RDQ_OP_RELEASE  4'h3
`define RDQ_OP_QUIESCE  4'h4
`define RDQ_OP_GENERATE 4'h6
`define RDQ_OP_ACK      4'h9

// Whole single-word packets
`define RDQ_WORD_ACK    16'h0009
`define RDQ_WORD_QUI    16'h0004

// Register byte offsets
`define RDQ_OFS_CTRL    8'h00
`define RDQ_OFS_SETHDR  8'h04
`define RDQ_OFS_SETNUM  8'h08
`define RDQ_OFS_STATUS  8'h0C
`define RDQ_OFS_GENINFO 8'h10
`define RDQ_OFS_GENTGT  8'h14
`define RDQ_OFS_GENAFF  8'h18
`define RDQ_OFS_RELNUM  8'h1C
`define RDQ_OFS_RELINFO 8'h20

// Control register bit positions
`define RDQ_CTRL_SEND_SET  0
`define RDQ_CTRL_SEND_QUI  1
`define RDQ_CTRL_RETIRE    2
`define RDQ_CTRL_DNACK     3
`define RDQ_CTRL_SECDIS    4
`define RDQ_CTRL_SECAFFOFF 5
`define RDQ_CTRL_TOPAFF    6
`define RDQ_CTRL_WAKE      7

// Reset values and limits
`define RDQ_RST_CTRL    5'h00
`define RDQ_RST_WORD    32'h0000_0000
`define RDQ_SET_MAX     2'd2
`define RDQ_ACK_STOP    3'd5

// Bus answers
`define RDQ_RESP_OKAY   2'b00
`define RDQ_RESP_SLVERR 2'b10

`endif

// file: rtl/rdq_pkg.sv
// Types shared by the soft-interrupt stream host files.
// Assumes nothing beyond a SystemVerilog compiler.
package rdq_pkg;
	typedef logic [15:0] rdq_word_t;
	typedef enum logic {
		RDQ_RX_HEAD = 1'b0,
		RDQ_RX_BODY = 1'b1
	} rdq_rx_t;
	typedef enum logic [1:0] {
		RDQ_K_NONE = 2'b00,
		RDQ_K_ACK  = 2'b01,
		RDQ_K_QUI  = 2'b10,
		RDQ_K_SET  = 2'b11
	} rdq_kind_t;
endpackage

// file: rtl/rdq_pkt_tx.sv
// Downstream packet sender: up to three 16-bit words, first word first.
// Assumes the receiver on the same clock and a load only while not busy.
`timescale 1ns/100ps
`default_nettype none
module rdq_pkt_tx (
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic              load,
	input  wire rdq_pkg::rdq_word_t w0,
	input  wire rdq_pkg::rdq_word_t w1,
	input  wire rdq_pkg::rdq_word_t w2,
	input  wire logic [1:0]        len,
	output logic                   busy,
	output logic [15:0]            dnData,
	output logic                   dnValid,
	input  wire logic              dnReady
);
	import rdq_pkg::*;

	rdq_word_t  bufW_r [1:2];
	logic [1:0] idx_r;
	logic [1:0] len_r;
	logic [15:0] dnData_r;
	logic       dnValid_r;

	// Words leave in packet order, lower number half first
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dnData_r  <= 16'h0000;
			dnValid_r <= 1'b0;
			bufW_r[1] <= 16'h0000;
			bufW_r[2] <= 16'h0000;
			idx_r     <= 2'd1;
			len_r     <= 2'd1;
		end else if (load && !dnValid_r) begin
			dnData_r  <= w0;
			dnValid_r <= 1'b1;
			bufW_r[1] <= w1;
			bufW_r[2] <= w2;
			len_r     <= len;
			idx_r     <= 2'd1;
		end else if (dnValid_r && dnReady) begin
			if (idx_r < len_r) begin
				dnData_r <= bufW_r[idx_r];
				idx_r    <= idx_r + 2'd1;
			end else begin
				dnValid_r <= 1'b0;
			end
		end
	end

	assign busy    = dnValid_r;
	assign dnData  = dnData_r;
	assign dnValid = dnValid_r;
endmodule
`default_nettype wire

// file: rtl/rdq_redist_host.sv
// Redistributor-side host of the soft-interrupt, quiesce, release and set stream.
// Assumes the processor interface on the same clock and software on AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "rdq_params.svh"

// Functional notes
// - Every generate command received is answered by one generate acknowledge.
// - Range selector is taken only when range-selector-valid is 1, else zero.
// - Without top-affinity-present, the top affinity is taken as zero.
// - In routing-mode-all, target list and affinities are ignored.
// - Secure affinity routing off, security enabled: non-secure group0/alias writes acknowledged, discarded.
// - Security disabled: such non-secure writes make a group 0 soft interrupt.
// - Without top-affinity support, top-affinity commands are acknowledged, not acted on.
// - Generate acknowledge is one word, opcode 9, upper bits zero.
// - Quiesce request is one word, opcode 4, upper bits zero.
// - No quiesce while a downstream control acknowledge is outstanding.
// - Released one-of-N interrupts may be resent anywhere by software.
// - Set word 0: priority, width code, qualifier, group, opcode 1.
// - At most two set commands await an answer at once.
module rdq_redist_host #(
	parameter int AW = 8
) (
	input  wire logic          clk,
	input  wire logic          rstn,
	input  wire logic [AW-1:0] awaddr,
	input  wire logic          awvalid,
	output logic               awready,
	input  wire logic [31:0]   wdata,
	input  wire logic [3:0]    wstrb,
	input  wire logic          wvalid,
	output logic               wready,
	output logic [1:0]         bresp,
	output logic               bvalid,
	input  wire logic          bready,
	input  wire logic [AW-1:0] araddr,
	input  wire logic          arvalid,
	output logic               arready,
	output logic [31:0]        rdata,
	output logic [1:0]         rresp,
	output logic               rvalid,
	input  wire logic          rready,
	output logic [15:0]        dnData,
	output logic               dnValid,
	input  wire logic          dnReady,
	input  wire rdq_pkg::rdq_word_t upData,
	input  wire logic          upValid,
	output logic               upReady
);
	import rdq_pkg::*;

	// Bus slave state
	logic          awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic          awHave_r, wHave_r;
	logic [AW-1:0] awAddr_r;
	logic [31:0]   wData_r, rdata_r;
	logic [3:0]    wStrb_r;
	logic [1:0]    bresp_r, rresp_r;
	logic          wrFire, rdErr;
	logic [31:0]   rdVal;
	// Software registers and pulses
	logic [4:0]    ctrl_r;
	logic [31:0]   setHdr_r, setNum_r;
	logic          cmdSet, cmdQui, cmdRetire, cmdWake;
	logic [4:0]    sticky_r, stickyClr, stickyEv;
	// Receive path
	rdq_rx_t       rxState_r;
	rdq_word_t     rxW_r [0:3];
	logic [1:0]    rxIdx_r, rxLast_r, hdRem;
	logic          upReady_r, upTake, pktDone_r;
	logic [3:0]    op;
	logic          genEv, relEv, qackEv, protoEv;
	// Recorded packets
	logic [15:0]   genInfo_r, genTgt_r, relInfo_r;
	logic [23:0]   genAff_r;
	logic [31:0]   relNum_r;
	logic          nsGrp0;
	// Transmit side
	logic [2:0]    ackPend_r;
	logic [1:0]    setOut_r;
	logic          setReq_r, quiReq_r, quiescing_r, quiesced_r;
	logic          txBusy, txLoad, setRefEv, quiRefEv, relPhys;
	rdq_kind_t     txKind;
	rdq_word_t     txW0, txW1, txW2;
	logic [1:0]    txLen;

	// Write channel acceptance, address and data in either order
	assign wrFire = awHave_r && wHave_r && !bvalid_r;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			awHave_r  <= 1'b0;
			wHave_r   <= 1'b0;
			awAddr_r  <= '0;
			wData_r   <= `RDQ_RST_WORD;
			wStrb_r   <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `RDQ_RESP_OKAY;
		end else begin
			if (awvalid && awready_r) begin
				awHave_r  <= 1'b1;
				awAddr_r  <= awaddr;
				awready_r <= 1'b0;
			end
			if (wvalid && wready_r) begin
				wHave_r  <= 1'b1;
				wData_r  <= wdata;
				wStrb_r  <= wstrb;
				wready_r <= 1'b0;
			end
			if (wrFire) begin
				awHave_r <= 1'b0;
				wHave_r  <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r  <= (awAddr_r > `RDQ_OFS_RELINFO || awAddr_r[1:0] != 2'b00) ?
					`RDQ_RESP_SLVERR : `RDQ_RESP_OKAY;
			end else if (bvalid_r && bready) begin
				bvalid_r  <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	// Register writes with byte lanes
	assign cmdSet    = wrFire && awAddr_r == `RDQ_OFS_CTRL && wStrb_r[0] &&
		wData_r[`RDQ_CTRL_SEND_SET];
	assign cmdQui    = wrFire && awAddr_r == `RDQ_OFS_CTRL && wStrb_r[0] &&
		wData_r[`RDQ_CTRL_SEND_QUI];
	assign cmdRetire = wrFire && awAddr_r == `RDQ_OFS_CTRL && wStrb_r[0] &&
		wData_r[`RDQ_CTRL_RETIRE];
	assign cmdWake   = wrFire && awAddr_r == `RDQ_OFS_CTRL && wStrb_r[0] &&
		wData_r[`RDQ_CTRL_WAKE];
	assign stickyClr = (wrFire && awAddr_r == `RDQ_OFS_STATUS && wStrb_r[0]) ?
		wData_r[8:4] : 5'h00;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_r   <= `RDQ_RST_CTRL;
			setHdr_r <= `RDQ_RST_WORD;
			setNum_r <= `RDQ_RST_WORD;
		end else if (wrFire) begin
			if (awAddr_r == `RDQ_OFS_CTRL) begin
				if (wStrb_r[0]) begin
					ctrl_r <= {wData_r[`RDQ_CTRL_TOPAFF], wData_r[`RDQ_CTRL_SECAFFOFF],
						wData_r[`RDQ_CTRL_SECDIS], wData_r[`RDQ_CTRL_DNACK], 1'b0};
				end
			end else if (awAddr_r == `RDQ_OFS_SETHDR) begin
				for (int i = 0; i < 4; i++) begin
					if (wStrb_r[i]) begin
						setHdr_r[8*i +: 8] <= wData_r[8*i +: 8];
					end
				end
			end else if (awAddr_r == `RDQ_OFS_SETNUM) begin
				for (int i = 0; i < 4; i++) begin
					if (wStrb_r[i]) begin
						setNum_r[8*i +: 8] <= wData_r[8*i +: 8];
					end
				end
			end
		end
	end

	// Read channel
	always_comb begin
		rdVal = 32'h0000_0000;
		rdErr = 1'b0;
		if (araddr == `RDQ_OFS_CTRL) begin
			rdVal = {25'h0, ctrl_r[4:1], 3'h0};
		end else if (araddr == `RDQ_OFS_SETHDR) begin
			rdVal = {20'h0, setHdr_r[11:0]};
		end else if (araddr == `RDQ_OFS_SETNUM) begin
			rdVal = setNum_r;
		end else if (araddr == `RDQ_OFS_STATUS) begin
			rdVal = {23'h0, sticky_r, quiesced_r, quiescing_r, setOut_r};
		end else if (araddr == `RDQ_OFS_GENINFO) begin
			rdVal = {16'h0, genInfo_r};
		end else if (araddr == `RDQ_OFS_GENTGT) begin
			rdVal = {16'h0, genTgt_r};
		end else if (araddr == `RDQ_OFS_GENAFF) begin
			rdVal = {8'h0, genAff_r};
		end else if (araddr == `RDQ_OFS_RELNUM) begin
			rdVal = relNum_r;
		end else if (araddr == `RDQ_OFS_RELINFO) begin
			rdVal = {16'h0, relInfo_r};
		end else begin
			rdErr = 1'b1;
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= `RDQ_RST_WORD;
			rresp_r   <= `RDQ_RESP_OKAY;
		end else if (arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rdata_r   <= rdVal;
			rresp_r   <= rdErr ? `RDQ_RESP_SLVERR : `RDQ_RESP_OKAY;
		end else if (rvalid_r && rready) begin
			rvalid_r  <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	// Upstream receive: length from the first word's opcode and flag bits
	assign upTake = upValid && upReady_r;
	always_comb begin
		hdRem = 2'd0;
		if (upData[3:0] == `RDQ_OP_GENERATE) begin
			hdRem = (upData[5] || upData[6]) ? 2'd3 : 2'd2;
		end else if (upData[3:0] == `RDQ_OP_RELEASE) begin
			hdRem = (upData[7:6] != 2'b00) ? 2'd2 : 2'd1;
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rxState_r <= RDQ_RX_HEAD;
			rxIdx_r   <= 2'd1;
			rxLast_r  <= 2'd1;
			pktDone_r <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				rxW_r[i] <= 16'h0000;
			end
		end else begin
			pktDone_r <= 1'b0;
			case (rxState_r)
				RDQ_RX_HEAD: begin
					if (upTake) begin
						rxW_r[0] <= upData;
						rxW_r[3] <= 16'h0000;
						rxIdx_r  <= 2'd1;
						rxLast_r <= hdRem;
						if (hdRem == 2'd0) begin
							pktDone_r <= 1'b1;
						end else begin
							rxState_r <= RDQ_RX_BODY;
						end
					end
				end
				RDQ_RX_BODY: begin
					if (upTake) begin
						rxW_r[rxIdx_r] <= upData;
						rxIdx_r        <= rxIdx_r + 2'd1;
						if (rxIdx_r == rxLast_r) begin
							pktDone_r <= 1'b1;
							rxState_r <= RDQ_RX_HEAD;
						end
					end
				end
				default: rxState_r <= RDQ_RX_HEAD;
			endcase
		end
	end

	// Packet events
	assign op      = rxW_r[0][3:0];
	assign genEv   = pktDone_r && op == `RDQ_OP_GENERATE;
	assign relEv   = pktDone_r && op == `RDQ_OP_RELEASE;
	assign qackEv  = pktDone_r && op == `RDQ_OP_ACK && quiescing_r;
	assign protoEv = pktDone_r && (quiesced_r || !(genEv || relEv || qackEv));
	assign nsGrp0  = rxW_r[0][7] && (rxW_r[0][9:8] == 2'b00 || rxW_r[0][9:8] == 2'b10);
	assign relPhys = relEv && !rxW_r[0][4];

	// Generate command record
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			genInfo_r <= 16'h0000;
			genTgt_r  <= 16'h0000;
			genAff_r  <= 24'h00_0000;
		end else if (genEv) begin
			genInfo_r[3:0]   <= rxW_r[0][15:12];
			genInfo_r[4]     <= ctrl_r[2] && nsGrp0;
			genInfo_r[7:5]   <= rxW_r[0][9:7];
			genInfo_r[8]     <= rxW_r[0][4];
			genInfo_r[9]     <= ctrl_r[3] && !ctrl_r[2] && nsGrp0;
			genInfo_r[10]    <= rxW_r[0][5] && !ctrl_r[4];
			genInfo_r[11]    <= rxW_r[0][6];
			genInfo_r[15:12] <= rxW_r[0][6] ? rxW_r[3][11:8] : 4'h0;
			genTgt_r         <= rxW_r[0][4] ? 16'h0000 : rxW_r[1];
			genAff_r[15:0]   <= rxW_r[0][4] ? 16'h0000 : rxW_r[2];
			genAff_r[23:16]  <= (rxW_r[0][4] || !rxW_r[0][5]) ? 8'h00 : rxW_r[3][7:0];
		end
	end

	// Release record, kept for software to resend
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			relNum_r  <= `RDQ_RST_WORD;
			relInfo_r <= 16'h0000;
		end else if (relEv) begin
			relNum_r  <= (rxW_r[0][7:6] != 2'b00) ? {rxW_r[2], rxW_r[1]} : {16'h0000, rxW_r[1]};
			relInfo_r <= {13'h0, rxW_r[0][7:6], rxW_r[0][4]};
		end
	end

	// Transmit choice: acknowledges first, then quiesce, then set
	always_comb begin
		txLoad = 1'b0;
		txKind = RDQ_K_NONE;
		txW0   = 16'h0000;
		txW1   = setNum_r[15:0];
		txW2   = setNum_r[31:16];
		txLen  = 2'd1;
		if (!txBusy) begin
			if (ackPend_r != 3'd0) begin
				txLoad = 1'b1;
				txKind = RDQ_K_ACK;
				txW0   = `RDQ_WORD_ACK;
			end else if (quiReq_r) begin
				txLoad = 1'b1;
				txKind = RDQ_K_QUI;
				txW0   = `RDQ_WORD_QUI;
			end else if (setReq_r) begin
				txLoad = 1'b1;
				txKind = RDQ_K_SET;
				txW0   = {setHdr_r[7:0], setHdr_r[9:8], setHdr_r[10], setHdr_r[11],
					`RDQ_OP_SET};
				txLen  = (setHdr_r[9:8] != 2'b00) ? 2'd3 : 2'd2;
			end
		end
	end

	rdq_pkt_tx u_tx (
		.clk     (clk),
		.rstn    (rstn),
		.load    (txLoad),
		.w0      (txW0),
		.w1      (txW1),
		.w2      (txW2),
		.len     (txLen),
		.busy    (txBusy),
		.dnData  (dnData),
		.dnValid (dnValid),
		.dnReady (dnReady)
	);

	// One acknowledge owed per generate command, upstream stalls when full
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ackPend_r <= 3'd0;
			upReady_r <= 1'b1;
		end else begin
			ackPend_r <= ackPend_r + {2'b00, genEv} - {2'b00, txKind == RDQ_K_ACK};
			upReady_r <= (ackPend_r + {2'b00, genEv}) < `RDQ_ACK_STOP;
		end
	end

	// Set requests and outstanding count
	assign setRefEv = cmdSet && (setReq_r || setOut_r >= `RDQ_SET_MAX || quiescing_r || quiesced_r);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			setReq_r <= 1'b0;
			setOut_r <= 2'd0;
		end else begin
			if (cmdSet && !setRefEv) begin
				setReq_r <= 1'b1;
			end else if (txKind == RDQ_K_SET) begin
				setReq_r <= 1'b0;
			end
			if (txKind == RDQ_K_SET && !((relPhys || cmdRetire) && setOut_r != 2'd0)) begin
				setOut_r <= setOut_r + 2'd1;
			end else if (txKind != RDQ_K_SET && (relPhys || cmdRetire) && setOut_r != 2'd0) begin
				setOut_r <= setOut_r - 2'd1;
			end
		end
	end

	// Quiesce handshake, refused while a downstream control answer is owed
	assign quiRefEv = cmdQui && (ctrl_r[1] || quiReq_r || quiescing_r || quiesced_r);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			quiReq_r    <= 1'b0;
			quiescing_r <= 1'b0;
			quiesced_r  <= 1'b0;
		end else begin
			if (cmdQui && !quiRefEv) begin
				quiReq_r <= 1'b1;
			end else if (txKind == RDQ_K_QUI) begin
				quiReq_r    <= 1'b0;
				quiescing_r <= 1'b1;
			end
			if (qackEv) begin
				quiescing_r <= 1'b0;
				quiesced_r  <= 1'b1;
			end else if (cmdWake) begin
				quiesced_r <= 1'b0;
			end
		end
	end

	// Sticky status, a new event wins over a clear
	assign stickyEv = {relEv, genEv, protoEv, quiRefEv, setRefEv};
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sticky_r <= 5'h00;
		end else begin
			sticky_r <= (sticky_r & ~stickyClr) | stickyEv;
		end
	end

	assign awready = awready_r;
	assign wready  = wready_r;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign arready = arready_r;
	assign rvalid  = rvalid_r;
	assign rdata   = rdata_r;
	assign rresp   = rresp_r;
	assign upReady = upReady_r;

	property p_ackWord;
		@(posedge clk) disable iff (!rstn)
		txKind == RDQ_K_ACK |=> dnValid && dnData == 16'h0009;
	endproperty
	a_ackWord: assert property (p_ackWord) else $error("ack word wrong");

	property p_ackOwed;
		@(posedge clk) disable iff (!rstn)
		genEv && txKind != RDQ_K_ACK |=> ackPend_r == $past(ackPend_r) + 3'd1;
	endproperty
	a_ackOwed: assert property (p_ackOwed) else $error("generate not owed ack");

	property p_quiWord;
		@(posedge clk) disable iff (!rstn)
		txKind == RDQ_K_QUI |=> dnValid && dnData == 16'h0004 ##1 (!dnValid || !$past(dnReady));
	endproperty
	a_quiWord: assert property (p_quiWord) else $error("quiesce word wrong");

	property p_quiDnAck;
		@(posedge clk) disable iff (!rstn)
		cmdQui && ctrl_r[1] && !quiReq_r |=> !quiReq_r;
	endproperty
	a_quiDnAck: assert property (p_quiDnAck) else $error("quiesce with owed ack");

	property p_setHead;
		@(posedge clk) disable iff (!rstn)
		txKind == RDQ_K_SET |=> dnData[3:0] == 4'h1 && dnData[15:8] == $past(setHdr_r[7:0]);
	endproperty
	a_setHead: assert property (p_setHead) else $error("set header wrong");

	property p_setLimit;
		@(posedge clk) disable iff (!rstn)
		txKind == RDQ_K_SET |-> setOut_r < 2'd2 ##1 setOut_r <= 2'd2;
	endproperty
	a_setLimit: assert property (p_setLimit) else $error("too many sets");

	property p_topZero;
		@(posedge clk) disable iff (!rstn)
		genEv && !rxW_r[0][5] |=> genAff_r[23:16] == 8'h00;
	endproperty
	a_topZero: assert property (p_topZero) else $error("top affinity not zero");

	property p_allMode;
		@(posedge clk) disable iff (!rstn)
		genEv && rxW_r[0][4] |=> genTgt_r == 16'h0000 && genAff_r == 24'h00_0000;
	endproperty
	a_allMode: assert property (p_allMode) else $error("targets kept in all mode");

	property p_discard;
		@(posedge clk) disable iff (!rstn)
		genEv && ctrl_r[3] && !ctrl_r[2] && nsGrp0 |=> genInfo_r[9] && !genInfo_r[4];
	endproperty
	a_discard: assert property (p_discard) else $error("discard missed");

	property p_grp0;
		@(posedge clk) disable iff (!rstn)
		genEv && ctrl_r[2] && nsGrp0 |=> genInfo_r[4] && !genInfo_r[9];
	endproperty
	a_grp0: assert property (p_grp0) else $error("group 0 missed");

	property p_topIgnore;
		@(posedge clk) disable iff (!rstn)
		genEv && rxW_r[0][5] && !ctrl_r[4] |=> genInfo_r[10] ##[0:8] ackPend_r == 3'd0 || dnValid;
	endproperty
	a_topIgnore: assert property (p_topIgnore) else $error("top affinity not ignored");
endmodule
`default_nettype wire

// file: tb/rdq_cpu_model.sv
// Behavioural processor interface facing the stream host.
// Assumes the host on the same clock; the bench queues upstream packets.
`timescale 1ns/100ps
`default_nettype none
`include "rdq_params.svh"
module rdq_cpu_model (
	input  wire logic          clk,
	input  wire logic          rstn,
	input  wire logic [15:0]   dnData,
	input  wire logic          dnValid,
	output logic               dnReady,
	output rdq_pkg::rdq_word_t upData,
	output logic               upValid,
	input  wire logic          upReady
);
	import rdq_pkg::*;
	rdq_word_t dnLog[$];
	rdq_word_t upQ[$];
	logic      slow = 1'b0;
	int        left = 0;
	task automatic gen(input logic [3:0] num, input logic routing_mode_all, ns, range_selector_valid, input logic [1:0] trigger_register_select,
		input logic [15:0] tl, input logic [23:0] aff, input logic [3:0] rs);
		logic a3v;
		a3v = (aff[23:16] != 8'h00) && !routing_mode_all;
		upQ.push_back({num, 2'b00, trigger_register_select, ns, range_selector_valid, a3v, routing_mode_all, `RDQ_OP_GENERATE});
		upQ.push_back(tl);
		upQ.push_back(aff[15:0]);
		if (a3v || range_selector_valid)
			upQ.push_back({4'h0, range_selector_valid ? rs : 4'h0, a3v ? aff[23:16] : 8'h00});
	endtask
	task automatic rel(input logic v, input logic [1:0] wc, input logic [31:0] num);
		upQ.push_back({8'h00, wc, 1'b0, v, `RDQ_OP_RELEASE});
		upQ.push_back(num[15:0]);
		if (wc != 2'b00)
			upQ.push_back({8'h00, num[23:16]});
	endtask
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dnReady <= 1'b0;
			upValid <= 1'b0;
			upData <= 16'h0000;
		end else begin
			dnReady <= slow ? !dnReady : 1'b1;
			if (dnValid && dnReady) begin
				dnLog.push_back(dnData);
				if (left != 0)
					left <= left - 1;
				else if (dnData[3:0] == `RDQ_OP_SET)
					left <= (dnData[7:6] != 2'b00) ? 2 : 1;
				else if (dnData == `RDQ_WORD_QUI)
					upQ.push_back(`RDQ_WORD_ACK);
			end
			if (upValid && upReady)
				void'(upQ.pop_front());
			if (!upValid || upReady) begin
				upValid <= upQ.size() != 0;
				upData <= (upQ.size() != 0) ? upQ[0] : ~upData;
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/test_rdq_redist_host.sv
// Self-checking bench of the stream host: bus, generate, set, release, quiesce.
// Assumes the host and the processor model, one 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none
`include "rdq_params.svh"
module test_rdq_redist_host;
	import rdq_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
	logic dnValid, dnReady, upValid, upReady;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, lastResp;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] bresp, rresp;
	logic [15:0] dnData;
	rdq_word_t upData;
	int fail_count = 0, samples_checked = 0, cycles = 0;
	rdq_redist_host #(.AW(8)) dut (.clk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .dnData, .dnValid, .dnReady, .upData, .upValid, .upReady);
	rdq_cpu_model cpu (.clk, .rstn, .dnData, .dnValid, .dnReady, .upData, .upValid, .upReady);
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			fail_count++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chkV(input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkW(input int i, input logic [15:0] exp);
		logic [15:0] got;
		got = (cpu.dnLog.size() > i) ? cpu.dnLog[i] : 16'hXXXX;
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t word=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (aw || w) begin
			@(posedge clk);
			if (aw && awready) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end
		while (!bvalid) @(posedge clk);
		bready <= 1'b0;
		chkV(32'(bresp), 32'(er));
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		while (!rvalid) @(posedge clk);
		rready <= 1'b0;
		d = rdata;
		lastResp = 32'(rresp);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		chkV(d, exp);
	endtask
	task automatic poll(input int b);
		logic [31:0] d;
		do rd(`RDQ_OFS_STATUS, d); while (!d[b]);
	endtask
	task automatic waitDn(input int n);
		while (cpu.dnLog.size() < n) @(posedge clk);
	endtask
	task automatic t_regs();
		rdc(`RDQ_OFS_CTRL, 32'h0);
		rdc(`RDQ_OFS_STATUS, 32'h0);
		rdc(8'h24, 32'h0);
		chkV(lastResp, 32'(`RDQ_RESP_SLVERR));
		wr(8'h24, 32'h1, `RDQ_RESP_SLVERR);
	endtask
	task automatic t_gen();
		logic [31:0] c, e;
		logic ns, routing_mode_all, range_selector_valid, a3v, hit;
		logic [1:0] sg;
		int k;
		k = 0;
		for (int p = 0; p < 3; p++) begin
			c = 32'h10 << p;
			wr(`RDQ_OFS_CTRL, c, `RDQ_RESP_OKAY);
			for (int s = 0; s < 6; s++) begin
				sg = 2'(s >> 1);
				ns = s[0];
				routing_mode_all = (s == 3);
				range_selector_valid = sg[0] ^ ns;
				a3v = ns && !routing_mode_all;
				hit = ns && (sg != 2'b01);
				cpu.gen(4'(k), routing_mode_all, ns, range_selector_valid, sg, 16'hA5C3, {ns ? 8'h56 : 8'h00, 16'h3412}, 4'hB);
				waitDn(k + 1);
				chkW(k, `RDQ_WORD_ACK);
				e = {16'h0, range_selector_valid ? 4'hB : 4'h0, range_selector_valid, a3v & !c[6], hit & c[5], routing_mode_all, sg, ns,
					hit & c[4], 4'(k)};
				rdc(`RDQ_OFS_GENINFO, e);
				rdc(`RDQ_OFS_GENTGT, routing_mode_all ? 32'h0 : 32'hA5C3);
				rdc(`RDQ_OFS_GENAFF, routing_mode_all ? 32'h0 : {8'h0, a3v ? 8'h56 : 8'h00, 16'h3412});
				k++;
			end
		end
	endtask
	task automatic t_set();
		int b;
		b = cpu.dnLog.size();
		cpu.slow = 1'b1;
		wr(`RDQ_OFS_STATUS, 32'h1F0, `RDQ_RESP_OKAY);
		wr(`RDQ_OFS_SETHDR, 32'h05C5, `RDQ_RESP_OKAY);
		wr(`RDQ_OFS_SETNUM, 32'h00AB_CDEF, `RDQ_RESP_OKAY);
		wr(`RDQ_OFS_CTRL, 32'h1, `RDQ_RESP_OKAY);
		waitDn(b + 3);
		chkW(b, 16'hC561);
		chkW(b + 1, 16'hCDEF);
		chkW(b + 2, 16'h00AB);
		rdc(`RDQ_OFS_STATUS, 32'h1);
		wr(`RDQ_OFS_CTRL, 32'h1, `RDQ_RESP_OKAY);
		waitDn(b + 6);
		wr(`RDQ_OFS_CTRL, 32'h1, `RDQ_RESP_OKAY);
		rdc(`RDQ_OFS_STATUS, 32'h12);
		cpu.rel(1'b0, 2'b01, 32'h00AB_CDEF);
		poll(8);
		rdc(`RDQ_OFS_STATUS, 32'h111);
		rdc(`RDQ_OFS_RELNUM, 32'h00AB_CDEF);
		rdc(`RDQ_OFS_RELINFO, 32'h2);
		wr(`RDQ_OFS_STATUS, 32'h1F0, `RDQ_RESP_OKAY);
		cpu.rel(1'b1, 2'b00, 32'h0123);
		poll(8);
		rdc(`RDQ_OFS_STATUS, 32'h101);
		rdc(`RDQ_OFS_RELNUM, 32'h0123);
		rdc(`RDQ_OFS_RELINFO, 32'h1);
		cpu.slow = 1'b0;
	endtask
	task automatic t_qui();
		logic [31:0] d;
		int b;
		wr(`RDQ_OFS_STATUS, 32'h1F0, `RDQ_RESP_OKAY);
		wr(`RDQ_OFS_CTRL, 32'h8, `RDQ_RESP_OKAY);
		wr(`RDQ_OFS_CTRL, 32'hA, `RDQ_RESP_OKAY);
		rdc(`RDQ_OFS_STATUS, 32'h21);
		wr(`RDQ_OFS_STATUS, 32'h1F0, `RDQ_RESP_OKAY);
		wr(`RDQ_OFS_CTRL, 32'h0, `RDQ_RESP_OKAY);
		b = cpu.dnLog.size();
		wr(`RDQ_OFS_CTRL, 32'h2, `RDQ_RESP_OKAY);
		waitDn(b + 1);
		chkW(b, `RDQ_WORD_QUI);
		poll(3);
		rdc(`RDQ_OFS_STATUS, 32'h9);
		wr(`RDQ_OFS_CTRL, 32'h1, `RDQ_RESP_OKAY);
		cpu.gen(4'h1, 1'b0, 1'b0, 1'b0, 2'b01, 16'h0001, 24'h0, 4'h0);
		poll(6);
		rd(`RDQ_OFS_STATUS, d);
		chkV(d & 32'h5F, 32'h59);
		waitDn(b + 2);
		chkW(b + 1, `RDQ_WORD_ACK);
		chkV(32'(cpu.dnLog.size()), 32'(b + 2));
		wr(`RDQ_OFS_CTRL, 32'h80, `RDQ_RESP_OKAY);
		rd(`RDQ_OFS_STATUS, d);
		chkV(d & 32'hF, 32'h1);
		wr(`RDQ_OFS_CTRL, 32'h4, `RDQ_RESP_OKAY);
		rd(`RDQ_OFS_STATUS, d);
		chkV(d & 32'hF, 32'h0);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_gen();
		t_set();
		t_qui();
		wrap_up();
	end
endmodule
`default_nettype wire
